// [debug_regs_pkg.sv]
// constants and types shared by the debug register bank
package debug_regs_pkg;

  // peripheral space: module number and register index
  localparam int unsigned    MODULE_COUNT   = 6;
  localparam logic [2:0]     MODULE_LAST    = 3'h5;
  localparam logic [2:0]     BANK_MODULE    = 3'h2;
  localparam logic [4:0]     INDEX_LAST     = 5'h1F;
  localparam int unsigned    INDEX_LSB      = 2;
  localparam int unsigned    INDEX_MSB      = 6;
  localparam int unsigned    MODULE_LSB     = 7;
  localparam int unsigned    MODULE_MSB     = 9;
  localparam int unsigned    ADDR_WIDTH     = 32;
  localparam int unsigned    DATA_WIDTH     = 32;

  // register indices; byte address is (module * 32 + index) * 4
  localparam logic [4:0]     IDX_SCRATCH_ZERO = 5'h18;
  localparam logic [4:0]     IDX_SCRATCH_ONE  = 5'h19;
  localparam logic [4:0]     IDX_CONTROL      = 5'h1A;
  localparam logic [4:0]     IDX_RESET_STATUS = 5'h1B;

  // field layout of debug_control
  localparam int unsigned    CTRL_BREAK_EN_BIT  = 7;
  localparam int unsigned    CTRL_REG_BREAK_BIT = 5;
  localparam int unsigned    CTRL_CMD_MSB       = 3;
  localparam int unsigned    CTRL_CMD_LSB       = 0;
  localparam logic [7:0]     CTRL_WRITE_MASK    = 8'hAF;

  // field layout of reset_status
  localparam int unsigned    RSTAT_POR_BIT      = 0;

  // values after reset
  localparam logic [15:0]    SCRATCH_RESET  = 16'h0000;
  localparam logic [7:0]     CONTROL_RESET  = 8'h00;
  localparam logic           POR_SEEN_RESET = 1'b1;

  // debug engine state codes
  localparam logic [1:0]     CODE_NON_DEBUG  = 2'h0;
  localparam logic [1:0]     CODE_DEBUG_IDLE = 2'h1;
  localparam logic [1:0]     CODE_DEBUG_BUSY = 2'h2;

  // bus answers
  localparam logic [1:0]     RESP_OKAY   = 2'h0;
  localparam logic [1:0]     RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    ENG_OFF  = 3'h1,
    ENG_IDLE = 3'h2,
    ENG_BUSY = 3'h4
  } engine_state_t;

endpackage

// [reg_access_if.sv]
// write path and stored values between bus front end and register store
interface reg_access_if;
  import debug_regs_pkg::*;

  logic        wr_en;
  logic [4:0]  wr_index;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [15:0] scratch_zero;
  logic [15:0] scratch_one;
  logic [7:0]  control;

  modport store (
    input  wr_en,
    input  wr_index,
    input  wr_data,
    input  wr_strb,
    output scratch_zero,
    output scratch_one,
    output control
  );

  modport front (
    output wr_en,
    output wr_index,
    output wr_data,
    output wr_strb,
    input  scratch_zero,
    input  scratch_one,
    input  control
  );
endinterface

// [debug_reg_store.sv]
// storage of the scratch and control registers
module debug_reg_store
  import debug_regs_pkg::*;
(
  // clock and combined reset
  input  wire logic clk,
  input  wire logic rst_n,
  // register access
  reg_access_if.store ra
);

  typedef struct packed {
    logic [15:0] scratch_zero;
    logic [15:0] scratch_one;
    logic [7:0]  control;
  } store_state_t;

  store_state_t s_q;
  store_state_t s_d;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] v;
    v = old_v;
    if (strb[0])
    begin
      v[7:0] = data[7:0];
    end
    if (strb[1])
    begin
      v[15:8] = data[15:8];
    end
    return v;
  endfunction

  always_comb
  begin
    s_d = s_q;
    if (ra.wr_en)
    begin
      case (ra.wr_index)
        IDX_SCRATCH_ZERO: s_d.scratch_zero = merge16(s_q.scratch_zero, ra.wr_data,
                                                     ra.wr_strb);
        IDX_SCRATCH_ONE:  s_d.scratch_one  = merge16(s_q.scratch_one, ra.wr_data,
                                                     ra.wr_strb);
        IDX_CONTROL:
        begin
          // reserved bits never store, so they read back zero
          if (ra.wr_strb[0])
          begin
            s_d.control = ra.wr_data[7:0] & CTRL_WRITE_MASK;
          end
        end
        default: s_d = s_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.scratch_zero <= SCRATCH_RESET;
      s_q.scratch_one  <= SCRATCH_RESET;
      s_q.control      <= CONTROL_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign ra.scratch_zero = s_q.scratch_zero;
  assign ra.scratch_one  = s_q.scratch_one;
  assign ra.control      = s_q.control;

endmodule // debug_reg_store

// [debug_peripheral_registers.sv]
// in-circuit debug register bank with AXI4-Lite slave and engine state
//
// Design decision made here: the AXI4-Lite slave port.

// Function
// - registers sit in module 2 of a space of modules 0-5, indices 00h-1Fh
// - two 16-bit scratch registers at 18h, 19h, reset zero, privileged access
// - 8-bit control at 1Ah: bit7 break enable, bit5 reg break, bits3-0 command
// - control bits 6 and 4 read zero; other bits privileged-only writes
// - power-on-only bits survive standard reset, set only by power-on reset, cleared by a write of one
// - engine state reads 00b outside debug, 10b while running host command
module debug_peripheral_registers
  import debug_regs_pkg::*;
(
  // clock and resets
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        POR_N,
  // cpu context, same clock domain
  input  wire logic        BACKGROUND_MODE,
  input  wire logic        DEBUG_MODE,
  // debug engine command progress, same clock domain
  input  wire logic        HOST_CMD_START,
  input  wire logic        HOST_CMD_DONE,
  // AXI4-Lite write address
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] AWADDR,
  input  wire logic [2:0]  AWPROT,
  // AXI4-Lite write data
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  // AXI4-Lite write response
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  // AXI4-Lite read address
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [31:0] ARADDR,
  input  wire logic [2:0]  ARPROT,
  // AXI4-Lite read data
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  // control outputs to the breakpoint and command logic
  output logic             BREAKPOINT_EN,
  output logic             REGISTER_BREAK_EN,
  output logic [3:0]       HOST_COMMAND_CODE,
  output logic [1:0]       DEBUG_STATE
);

  typedef struct packed {
    logic          aw_held;
    logic [31:0]   aw_addr;
    logic          w_held;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    engine_state_t eng;
    logic [1:0]    dbg_code;
  } front_state_t;

  front_state_t s_q;
  front_state_t s_d;
  logic         por_seen_q;
  logic         rst_n;
  logic         priv;
  logic         wr_fire;
  logic         wr_hit;
  logic         por_clear;

  reg_access_if ra ();

  // standard reset also follows power-on reset
  assign rst_n = RESET_N & POR_N;

  // background or debug context opens the special access
  assign priv = BACKGROUND_MODE | DEBUG_MODE;

  debug_reg_store u_store (
    .clk   (CLK),
    .rst_n (rst_n),
    .ra    (ra)
  );

  // hit for the address of a mapped register, else miss
  function automatic logic reg_hit(input logic [31:0] addr);
    logic [4:0] idx;
    logic       ok;
    idx = addr[INDEX_MSB:INDEX_LSB];
    // one aligned word per register; a byte offset inside it misses
    ok  = (addr[ADDR_WIDTH-1:MODULE_MSB+1] == '0) &&
          (addr[INDEX_LSB-1:0] == '0) &&
          (addr[MODULE_MSB:MODULE_LSB] == BANK_MODULE);
    return ok && ((idx == IDX_SCRATCH_ZERO) || (idx == IDX_SCRATCH_ONE) ||
                  (idx == IDX_CONTROL) || (idx == IDX_RESET_STATUS));
  endfunction

  // index bits only; module bits are checked by reg_hit
  function automatic logic [4:0] reg_index(input logic [31:0] addr);
    return addr[INDEX_MSB:INDEX_LSB];
  endfunction

  // engine state as the two-bit code the host sees
  function automatic logic [1:0] state_code(input engine_state_t e);
    logic [1:0] c;
    case (e)
      ENG_IDLE: c = CODE_DEBUG_IDLE;
      ENG_BUSY: c = CODE_DEBUG_BUSY;
      default:  c = CODE_NON_DEBUG;
    endcase
    return c;
  endfunction

  // read value of a register as the bus sees it
  function automatic logic [31:0] read_word(input logic [4:0]  idx,
                                            input logic        p,
                                            input logic [15:0] t0,
                                            input logic [15:0] t1,
                                            input logic [7:0]  ctl,
                                            input logic        por);
    logic [31:0] v;
    v = '0;
    case (idx)
      IDX_SCRATCH_ZERO:
      begin
        if (p)
        begin
          v[15:0] = t0;
        end
      end
      IDX_SCRATCH_ONE:
      begin
        if (p)
        begin
          v[15:0] = t1;
        end
      end
      IDX_CONTROL:      v[7:0] = ctl & CTRL_WRITE_MASK;
      IDX_RESET_STATUS: v[RSTAT_POR_BIT] = por;
      default:          v = '0;
    endcase
    return v;
  endfunction

  // one write per response; ready drops while a word is held
  assign AWREADY = !s_q.aw_held && !s_q.bvalid;
  assign WREADY  = !s_q.w_held && !s_q.bvalid;
  // one read in flight; no read buffer, so the next address waits
  assign ARREADY = !s_q.rvalid;

  // fires once both halves are held and the last answer was taken
  assign wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;
  assign wr_hit  = reg_hit(s_q.aw_addr);

  // scratch and control ignore writes outside the privileged context
  assign ra.wr_en    = wr_fire && wr_hit && priv &&
                       (reg_index(s_q.aw_addr) != IDX_RESET_STATUS);
  assign ra.wr_index = reg_index(s_q.aw_addr);
  assign ra.wr_data  = s_q.w_data;
  assign ra.wr_strb  = s_q.w_strb;

  // write-one-to-clear of the power-on flag, open in every context
  assign por_clear = wr_fire && wr_hit &&
                     (reg_index(s_q.aw_addr) == IDX_RESET_STATUS) &&
                     s_q.w_strb[0] && s_q.w_data[RSTAT_POR_BIT];

  always_comb
  begin
    s_d = s_q;
    if (AWVALID && AWREADY)
    begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = AWADDR;
    end
    if (WVALID && WREADY)
    begin
      s_d.w_held = 1'b1;
      s_d.w_data = WDATA;
      s_d.w_strb = WSTRB;
    end
    if (wr_fire)
    begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = wr_hit ? RESP_OKAY : RESP_DECERR;
    end
    if (s_q.bvalid && BREADY)
    begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && RREADY)
    begin
      s_d.rvalid = 1'b0;
    end
    // read data captured at the address edge, so a later write cannot tear it
    if (ARVALID && ARREADY)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = reg_hit(ARADDR) ? RESP_OKAY : RESP_DECERR;
      s_d.rdata  = read_word(reg_index(ARADDR), priv, ra.scratch_zero,
                             ra.scratch_one, ra.control, por_seen_q);
      if (!reg_hit(ARADDR))
      begin
        s_d.rdata = '0;
      end
    end
    // engine state follows debug mode and host commands
    case (s_q.eng)
      ENG_OFF:
      begin
        if (DEBUG_MODE)
        begin
          s_d.eng = HOST_CMD_START ? ENG_BUSY : ENG_IDLE;
        end
      end
      ENG_IDLE:
      begin
        if (!DEBUG_MODE)
        begin
          s_d.eng = ENG_OFF;
        end
        else if (HOST_CMD_START)
        begin
          s_d.eng = ENG_BUSY;
        end
      end
      ENG_BUSY:
      begin
        // a command such as return leaves debug mode directly
        if (!DEBUG_MODE)
        begin
          s_d.eng = ENG_OFF;
        end
        else if (HOST_CMD_DONE)
        begin
          s_d.eng = ENG_IDLE;
        end
      end
      // a broken one-hot code falls back to off
      default: s_d.eng = ENG_OFF;
    endcase
    // code comes from a flop so the host never sees a decode glitch
    s_d.dbg_code = state_code(s_d.eng);
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.aw_held <= 1'b0;
      s_q.aw_addr <= 32'h0000_0000;
      s_q.w_held  <= 1'b0;
      s_q.w_data  <= 32'h0000_0000;
      s_q.w_strb  <= 4'h0;
      s_q.bvalid  <= 1'b0;
      s_q.bresp   <= RESP_OKAY;
      s_q.rvalid  <= 1'b0;
      s_q.rdata   <= 32'h0000_0000;
      s_q.rresp   <= RESP_OKAY;
      s_q.eng     <= ENG_OFF;
      s_q.dbg_code <= CODE_NON_DEBUG;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // kept apart: of the two resets, only power-on reset may touch this flag
  always_ff @(posedge CLK or negedge POR_N)
  begin
    if (!POR_N)
    begin
      por_seen_q <= POR_SEEN_RESET;
    end
    else if (por_clear)
    begin
      por_seen_q <= 1'b0;
    end
  end

  // bus answers straight from the registered state
  assign BVALID = s_q.bvalid;
  assign BRESP  = s_q.bresp;
  assign RVALID = s_q.rvalid;
  assign RDATA  = s_q.rdata;
  assign RRESP  = s_q.rresp;

  // control fields go straight out of the store flops
  assign BREAKPOINT_EN     = ra.control[CTRL_BREAK_EN_BIT];
  assign REGISTER_BREAK_EN = ra.control[CTRL_REG_BREAK_BIT];
  assign HOST_COMMAND_CODE = ra.control[CTRL_CMD_MSB:CTRL_CMD_LSB];

  assign DEBUG_STATE = s_q.dbg_code;

endmodule // debug_peripheral_registers

// [dbg_checker.sv]
// port assertions for the debug register bank
module dbg_checker
  import debug_regs_pkg::*;
(
  // clock, resets, context
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        POR_N,
  input wire logic        BACKGROUND_MODE,
  input wire logic        DEBUG_MODE,
  input wire logic        HOST_CMD_START,
  input wire logic        HOST_CMD_DONE,
  // read path
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] ARADDR,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  // control outputs
  input wire logic        BREAKPOINT_EN,
  input wire logic        REGISTER_BREAK_EN,
  input wire logic [3:0]  HOST_COMMAND_CODE,
  input wire logic [1:0]  DEBUG_STATE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N || !POR_N);
  logic take;
  logic priv;
  assign take = ARVALID && ARREADY;
  assign priv = BACKGROUND_MODE || DEBUG_MODE;
  a_state_off: assert property (!DEBUG_MODE |=> DEBUG_STATE == 2'h0)
    else $error("engine state not off outside debug");
  a_state_busy: assert property (DEBUG_MODE && HOST_CMD_START && !HOST_CMD_DONE
    |=> DEBUG_STATE == 2'h2) else $error("engine state not busy after start");
  a_busy_holds: assert property (DEBUG_STATE == 2'h2 && DEBUG_MODE && !HOST_CMD_DONE
    |=> DEBUG_STATE == 2'h2) else $error("busy state dropped early");
  a_read_decerr: assert property (take && (ARADDR[31:10] != 22'h0 || ARADDR[9:7] != 3'h2)
    |=> RRESP == 2'h3 && RDATA == 32'h0) else $error("unmapped read answered");
  a_ctrl_readback: assert property (take && ARADDR == 32'h168 |=> RDATA == {24'h0,
    $past(BREAKPOINT_EN), 1'b0, $past(REGISTER_BREAK_EN), 1'b0, $past(HOST_COMMAND_CODE)})
    else $error("control read differs from outputs");
  a_scratch_gated: assert property (take && ARADDR[31:3] == 29'h2C && !priv
    |=> RDATA == 32'h0) else $error("scratch visible outside debug");
  a_scratch_width: assert property (take && ARADDR[31:3] == 29'h2C
    |=> RDATA[31:16] == 16'h0) else $error("scratch upper bits set");
  a_ctrl_priv_write: assert property ($changed({BREAKPOINT_EN, REGISTER_BREAK_EN,
    HOST_COMMAND_CODE}) |-> $past(priv)) else $error("control changed without privilege");
endmodule // dbg_checker

bind debug_peripheral_registers dbg_checker chk (
  .CLK, .RESET_N, .POR_N, .BACKGROUND_MODE, .DEBUG_MODE, .HOST_CMD_START,
  .HOST_CMD_DONE, .ARVALID, .ARREADY, .ARADDR, .RDATA, .RRESP, .BREAKPOINT_EN,
  .REGISTER_BREAK_EN, .HOST_COMMAND_CODE, .DEBUG_STATE
);

// [engine_model.sv]
// stand-in for the debug host engine: start and done pulses
module engine_model
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // command request and its length
  input wire logic       go,
  input wire logic [3:0] hold,
  // progress pulses
  output logic           start,
  output logic           done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] left_q;
  // one command at a time; done never shares a cycle with start
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      {left_q, start, done} <= 7'h00;
    else
    begin
      start  <= go && left_q == 5'h00;
      done   <= left_q == 5'h01;
      left_q <= (go && left_q == 5'h00) ? {1'b0, hold} + 5'h02
              : left_q - {4'h0, left_q != 5'h00};
    end
  end
endmodule // engine_model

// [tb_top.sv]
// self-checking bench for the debug register bank
module tb_top
  import debug_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, RESET_N, POR_N, BACKGROUND_MODE, DEBUG_MODE, go;
  logic        AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY;
  logic        HOST_CMD_START, HOST_CMD_DONE, BVALID, ARREADY, RVALID;
  logic        BREAKPOINT_EN, REGISTER_BREAK_EN;
  logic [31:0] AWADDR, WDATA, ARADDR, RDATA;
  logic [1:0]  BRESP, RRESP, DEBUG_STATE;
  logic [3:0]  HOST_COMMAND_CODE, WSTRB, hold;
  logic [2:0]  AWPROT, ARPROT;
  int          n_fail, n_compared;
  logic [31:0] ctl_out;
  typedef struct {
    logic [31:0] wa, wd;
    logic [1:0]  wm, wx;
    logic [31:0] ra;
    logic [1:0]  rm;
    logic [31:0] rv;
    logic [1:0]  rx;
  } row_t;
  // write, then read back; modes are {debug, background}
  row_t rows [9] = '{
    '{32'h160, 32'h1234ABCD, 2'h1, 2'h0, 32'h160, 2'h1, 32'h0000ABCD, 2'h0},
    '{32'h164, 32'h0000FFFF, 2'h2, 2'h0, 32'h164, 2'h2, 32'h0000FFFF, 2'h0},
    '{32'h168, 32'h000000FF, 2'h2, 2'h0, 32'h168, 2'h0, 32'h000000AF, 2'h0},
    '{32'h160, 32'h00005555, 2'h0, 2'h0, 32'h160, 2'h0, 32'h00000000, 2'h0},
    '{32'h164, 32'h00001111, 2'h0, 2'h0, 32'h164, 2'h1, 32'h0000FFFF, 2'h0},
    '{32'h168, 32'h00000000, 2'h0, 2'h0, 32'h168, 2'h1, 32'h000000AF, 2'h0},
    '{32'h1E0, 32'h00000007, 2'h1, 2'h3, 32'h1E0, 2'h1, 32'h00000000, 2'h3},
    '{32'h560, 32'h00000007, 2'h1, 2'h3, 32'h160, 2'h1, 32'h0000ABCD, 2'h0},
    '{32'h170, 32'h00000007, 2'h1, 2'h3, 32'h170, 2'h1, 32'h00000000, 2'h3}
  };
  debug_peripheral_registers dut (
    .CLK, .RESET_N, .POR_N, .BACKGROUND_MODE, .DEBUG_MODE, .HOST_CMD_START,
    .HOST_CMD_DONE, .AWVALID, .AWREADY, .AWADDR, .AWPROT, .WVALID, .WREADY,
    .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR,
    .ARPROT, .RVALID, .RREADY, .RDATA, .RRESP, .BREAKPOINT_EN,
    .REGISTER_BREAK_EN, .HOST_COMMAND_CODE, .DEBUG_STATE
  );
  engine_model host (.clk(CLK), .rst_n(RESET_N), .go(go), .hold(hold),
    .start(HOST_CMD_START), .done(HOST_CMD_DONE));
  assign ctl_out = {26'h0, BREAKPOINT_EN, REGISTER_BREAK_EN, HOST_COMMAND_CODE};
  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // whole run is under two hundred cycles
  initial
  begin
    #20000;
    n_fail++;
    final_report;
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic bus_wr(input logic [31:0] a, d, input logic [1:0] m, er);
    logic aw;
    logic w;
    {DEBUG_MODE, BACKGROUND_MODE} <= m;
    @(posedge CLK);
    {aw, w} = 2'h0;
    {AWVALID, WVALID, BREADY, AWADDR, WDATA} <= {3'h7, a, d};
    // address and data may be taken on different edges
    while (!(aw && w))
    begin
      @(posedge CLK);
      aw = aw | AWREADY;
      w = w | WREADY;
      AWVALID <= !aw;
      WVALID <= !w;
    end
    do @(posedge CLK); while (BVALID !== 1'b1);
    BREADY <= 1'b0;
    cmp("write response", {30'h0, er}, {30'h0, BRESP});
  endtask
  task automatic bus_rd(input logic [31:0] a, input logic [1:0] m,
                        input logic [31:0] ev, input logic [1:0] er);
    {DEBUG_MODE, BACKGROUND_MODE} <= m;
    @(posedge CLK);
    {ARVALID, RREADY, ARADDR} <= {2'h3, a};
    do @(posedge CLK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do @(posedge CLK); while (RVALID !== 1'b1);
    RREADY <= 1'b0;
    cmp("read data", ev, RDATA);
    cmp("read response", {30'h0, er}, {30'h0, RRESP});
  endtask
  task automatic pulse(input logic por);
    @(posedge CLK);
    {RESET_N, POR_N} <= {por, !por};
    repeat (2) @(posedge CLK);
    {RESET_N, POR_N} <= 2'h3;
    @(posedge CLK);
  endtask
  initial
  begin
    {RESET_N, POR_N, BACKGROUND_MODE, DEBUG_MODE, go, hold} = 9'h000;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    {AWADDR, WDATA, ARADDR, AWPROT, ARPROT} = 102'h0;
    WSTRB = 4'hF;
    n_fail = 0;
    n_compared = 0;
    repeat (2) @(posedge CLK);
    {RESET_N, POR_N} <= 2'h3;
    @(posedge CLK);
    foreach (rows[i])
    begin
      bus_wr(rows[i].wa, rows[i].wd, rows[i].wm, rows[i].wx);
      bus_rd(rows[i].ra, rows[i].rm, rows[i].rv, rows[i].rx);
    end
    cmp("control outputs", 32'h0000003F, ctl_out);
    $display("register table test done");
    {DEBUG_MODE, BACKGROUND_MODE} <= 2'h2;
    tick(2);
    cmp("engine idle", {30'h0, CODE_DEBUG_IDLE}, {30'h0, DEBUG_STATE});
    // prompt host, then slow host
    for (int h = 0; h < 16; h += 9)
    begin
      hold <= h[3:0];
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      while (HOST_CMD_START !== 1'b1) tick(1);
      tick(1);
      cmp("engine busy", {30'h0, CODE_DEBUG_BUSY}, {30'h0, DEBUG_STATE});
      while (HOST_CMD_DONE !== 1'b1) tick(1);
      tick(1);
      cmp("engine done", {30'h0, CODE_DEBUG_IDLE}, {30'h0, DEBUG_STATE});
    end
    DEBUG_MODE <= 1'b0;
    tick(2);
    cmp("engine off", {30'h0, CODE_NON_DEBUG}, {30'h0, DEBUG_STATE});
    $display("engine state test done");
    pulse(1'b0);
    cmp("control outputs after reset", 32'h00000000, ctl_out);
    bus_rd(32'h160, 2'h1, 32'h0, RESP_OKAY);
    bus_rd(32'h168, 2'h1, 32'h0, RESP_OKAY);
    bus_rd(32'h16C, 2'h0, 32'h1, RESP_OKAY);
    bus_wr(32'h16C, 32'h1, 2'h0, RESP_OKAY);
    pulse(1'b0);
    bus_rd(32'h16C, 2'h0, 32'h0, RESP_OKAY);
    pulse(1'b1);
    bus_rd(32'h16C, 2'h0, 32'h1, RESP_OKAY);
    $display("reset test done");
    final_report;
  end
endmodule // tb_top
